// ==== rtl/sebfe_regs.vh ====
// constants for the sensor and eeprom two-wire front end
`ifndef SEBFE_REGS_VH
`define SEBFE_REGS_VH

// timebase
`define SEBFE_CLK_KHZ                125000
`define SEBFE_CLK_MHZ                125

// power-on timing, in ms
`define SEBFE_RESET_COMPLETE_TIME_MS 10
`define SEBFE_INIT_WAIT_TIME_MS      10
// ten ms of the 125 MHz timebase, sized to the 24-bit init counter
`define SEBFE_RESET_COMPLETE_CYCLES  24'h1312D0

// scl low timeout window, in us
`define SEBFE_SCL_LOW_TIMEOUT_MIN_US 25
`define SEBFE_SCL_LOW_TIMEOUT_MAX_US 35
`define SEBFE_SCL_LOW_TIMEOUT_MIN_CYCLES        (`SEBFE_SCL_LOW_TIMEOUT_MIN_US * `SEBFE_CLK_MHZ)
`define SEBFE_SCL_LOW_TIMEOUT_MAX_CYCLES        (`SEBFE_SCL_LOW_TIMEOUT_MAX_US * `SEBFE_CLK_MHZ)
// window midpoint, sized to the 16-bit low counter
`define SEBFE_SCL_LOW_TIMEOUT_TERMINAL_CYCLES   16'h0EA6

// address byte layout
`define SEBFE_TYPE_MSB               7
`define SEBFE_TYPE_LSB               4
`define SEBFE_ADDR_MSB               3
`define SEBFE_ADDR_LSB               1
`define SEBFE_RW_BIT                 0
`define SEBFE_TYPE_EEPROM            4'hA
`define SEBFE_TYPE_PROTECT           4'h6
`define SEBFE_TYPE_SENSOR            4'h3
`define SEBFE_ADDR_BITS              4'h8

// power-on defaults
`define SEBFE_POINTER_DEFAULT        8'h00
`define SEBFE_LIMIT_DEFAULT          16'h0000
`define SEBFE_HYST_DEFAULT           2'h0
`define SEBFE_PAGE_DEFAULT           1'h0

`endif

// ==== rtl/sebfe_sync.v ====
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps

module sebfe_sync #(
   parameter WIDTH    = 1,
   parameter RESET_HI = 1
) (
   input  wire             clk,
   input  wire             rst_n,
   input  wire [WIDTH-1:0] asyncIn,
   output reg  [WIDTH-1:0] syncOut
);

   reg [WIDTH-1:0] stage1;

   always @(posedge clk) begin
      if (!rst_n) begin
         stage1  <= {WIDTH{RESET_HI[0]}};
         syncOut <= {WIDTH{RESET_HI[0]}};
      end else begin
         stage1  <= asyncIn;
         syncOut <= stage1;
      end
   end

endmodule // sebfe_sync

// ==== rtl/sebfe_front_end.v ====
// two-wire slave front end: power-on, standby, timeout, address decode
`timescale 1ns/1ps
`include "sebfe_regs.vh"

module sebfe_front_end #(
   parameter [23:0] RESET_COMPLETE_CYCLES = `SEBFE_RESET_COMPLETE_CYCLES,
   parameter [15:0] TIMEOUT_CYCLES        = `SEBFE_SCL_LOW_TIMEOUT_TERMINAL_CYCLES
) (
   input  wire        clk,
   input  wire        rst_n,
   input  wire        sclIn,
   input  wire        sdaIn,
   output reg         sdaOut,
   output reg         sdaOe,
   input  wire [2:0]  strapAddressPins,
   input  wire        pendingOperation,
   output reg         alertOut,
   output reg         alertOe,
   output reg         resetComplete,
   output reg         standby,
   output reg         sensorMonitoring,
   output reg  [7:0]  registerPointer,
   output reg  [15:0] upperLimit,
   output reg  [15:0] lowerLimit,
   output reg  [15:0] criticalLimit,
   output reg  [1:0]  hysteresis,
   output reg         alertInterruptMode,
   output reg         alertActiveHigh,
   output reg         alertEnable,
   output reg         eepromPageSelect,
   output reg         startDetect,
   output reg         stopDetect,
   output reg         busTimeout,
   output reg         addressAck,
   output reg         addressNack,
   output reg         selectEeprom,
   output reg         selectProtect,
   output reg         selectSensor,
   output reg         readMode
);

   // ------------------------------------------------------------
   // states
   // ------------------------------------------------------------
   localparam [2:0] ST_IDLE     = 3'h0;
   localparam [2:0] ST_ADDR     = 3'h1;
   localparam [2:0] ST_ACK_WAIT = 3'h2;
   localparam [2:0] ST_ACK_DRV  = 3'h3;
   localparam [2:0] ST_ACK_END  = 3'h4;
   localparam [2:0] ST_SELECTED = 3'h5;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   wire       sclSync;
   wire       sdaSync;
   wire [2:0] strapSync;
   reg        sclPrev;
   reg        sdaPrev;

   sebfe_sync #(.WIDTH(1), .RESET_HI(1)) sclSyncInst (
      .clk     (clk),
      .rst_n   (rst_n),
      .asyncIn (sclIn),
      .syncOut (sclSync)
   );

   sebfe_sync #(.WIDTH(1), .RESET_HI(1)) sdaSyncInst (
      .clk     (clk),
      .rst_n   (rst_n),
      .asyncIn (sdaIn),
      .syncOut (sdaSync)
   );

   sebfe_sync #(.WIDTH(3), .RESET_HI(0)) strapSyncInst (
      .clk     (clk),
      .rst_n   (rst_n),
      .asyncIn (strapAddressPins),
      .syncOut (strapSync)
   );

   always @(posedge clk) begin
      if (!rst_n) begin
         sclPrev <= 1'b1;
         sdaPrev <= 1'b1;
      end else begin
         sclPrev <= sclSync;
         sdaPrev <= sdaSync;
      end
   end

   wire sclRise = sclSync & ~sclPrev;
   wire sclFall = ~sclSync & sclPrev;
   wire startCond = sclSync & sclPrev & sdaPrev & ~sdaSync;
   wire stopCond  = sclSync & sclPrev & ~sdaPrev & sdaSync;

   // ------------------------------------------------------------
   // power-on internal reset
   // ------------------------------------------------------------
   reg [23:0] initCount;

   always @(posedge clk) begin
      if (!rst_n) begin
         initCount     <= 24'h000000;
         resetComplete <= 1'b0;
      end else if (!resetComplete) begin
         if (initCount == RESET_COMPLETE_CYCLES - 24'h000001) begin
            resetComplete <= 1'b1;
         end else begin
            initCount <= initCount + 24'h000001;
         end
      end
   end

   // ------------------------------------------------------------
   // power-on defaults
   // ------------------------------------------------------------
   // held at defaults here except sensorMonitoring, which follows resetComplete; register writes live in the sensor core
   always @(posedge clk) begin
      if (!rst_n) begin
         sensorMonitoring   <= 1'b0;
         registerPointer    <= `SEBFE_POINTER_DEFAULT;
         upperLimit         <= `SEBFE_LIMIT_DEFAULT;
         lowerLimit         <= `SEBFE_LIMIT_DEFAULT;
         criticalLimit      <= `SEBFE_LIMIT_DEFAULT;
         hysteresis         <= `SEBFE_HYST_DEFAULT;
         alertInterruptMode <= 1'b0;
         alertActiveHigh    <= 1'b0;
         alertEnable        <= 1'b0;
         eepromPageSelect   <= `SEBFE_PAGE_DEFAULT;
         alertOut           <= 1'b0;
         alertOe            <= 1'b0;
      end else begin
         sensorMonitoring   <= resetComplete;
         registerPointer    <= `SEBFE_POINTER_DEFAULT;
         upperLimit         <= `SEBFE_LIMIT_DEFAULT;
         lowerLimit         <= `SEBFE_LIMIT_DEFAULT;
         criticalLimit      <= `SEBFE_LIMIT_DEFAULT;
         hysteresis         <= `SEBFE_HYST_DEFAULT;
         alertInterruptMode <= 1'b0;
         alertActiveHigh    <= 1'b0;
         alertEnable        <= 1'b0;
         alertOut           <= 1'b0;
         alertOe            <= 1'b0;
         eepromPageSelect   <= `SEBFE_PAGE_DEFAULT;
      end
   end

   // ------------------------------------------------------------
   // scl low timeout
   // ------------------------------------------------------------
   reg [15:0] sclLowCount;
   wire       timeoutHit = (sclLowCount == TIMEOUT_CYCLES - 16'h0001);

   always @(posedge clk) begin
      if (!rst_n) begin
         sclLowCount <= 16'h0000;
      end else if (sclSync) begin
         sclLowCount <= 16'h0000;
      end else if (!timeoutHit) begin
         sclLowCount <= sclLowCount + 16'h0001;
      end
   end

   // ------------------------------------------------------------
   // address byte receiver
   // ------------------------------------------------------------
   reg [2:0] state;
   reg [7:0] shiftReg;
   reg [3:0] bitCount;
   reg       timeoutLatched;

   wire [7:0] addrByte   = {shiftReg[6:0], sdaSync};
   wire [3:0] typeId     = addrByte[`SEBFE_TYPE_MSB:`SEBFE_TYPE_LSB];
   wire       strapMatch = (addrByte[`SEBFE_ADDR_MSB:`SEBFE_ADDR_LSB] == strapSync);
   wire       isEeprom   = (typeId == `SEBFE_TYPE_EEPROM);
   wire       isProtect  = (typeId == `SEBFE_TYPE_PROTECT);
   wire       isSensor   = (typeId == `SEBFE_TYPE_SENSOR);
   wire       addrMatch  = strapMatch & (isEeprom | isProtect | isSensor);

   always @(posedge clk) begin
      if (!rst_n) begin
         state          <= ST_IDLE;
         shiftReg       <= 8'h00;
         bitCount       <= 4'h0;
         timeoutLatched <= 1'b0;
         sdaOut         <= 1'b0;
         sdaOe          <= 1'b0;
         standby        <= 1'b1;
         startDetect    <= 1'b0;
         stopDetect     <= 1'b0;
         busTimeout     <= 1'b0;
         addressAck     <= 1'b0;
         addressNack    <= 1'b0;
         selectEeprom   <= 1'b0;
         selectProtect  <= 1'b0;
         selectSensor   <= 1'b0;
         readMode       <= 1'b0;
      end else begin
         sdaOut      <= 1'b0;
         startDetect <= 1'b0;
         stopDetect  <= 1'b0;
         busTimeout  <= 1'b0;
         addressAck  <= 1'b0;
         addressNack <= 1'b0;
         // standby when idle and no work pending
         standby     <= (state == ST_IDLE) & ~pendingOperation;
         if (sclSync) begin
            timeoutLatched <= 1'b0;
         end
         if (!resetComplete) begin
            state <= ST_IDLE;
            sdaOe <= 1'b0;
         end else if (timeoutHit && !timeoutLatched && state != ST_IDLE) begin
            state          <= ST_IDLE;
            sdaOe          <= 1'b0;
            busTimeout     <= 1'b1;
            timeoutLatched <= 1'b1;
            selectEeprom   <= 1'b0;
            selectProtect  <= 1'b0;
            selectSensor   <= 1'b0;
         end else if (startCond) begin
            state         <= ST_ADDR;
            bitCount      <= 4'h0;
            sdaOe         <= 1'b0;
            startDetect   <= 1'b1;
            selectEeprom  <= 1'b0;
            selectProtect <= 1'b0;
            selectSensor  <= 1'b0;
         end else if (stopCond) begin
            state         <= ST_IDLE;
            sdaOe         <= 1'b0;
            stopDetect    <= 1'b1;
            selectEeprom  <= 1'b0;
            selectProtect <= 1'b0;
            selectSensor  <= 1'b0;
         end else begin
            case (state)
               ST_IDLE: begin
                  sdaOe <= 1'b0;
               end
               ST_ADDR: begin
                  if (sclRise) begin
                     shiftReg <= addrByte;
                     bitCount <= bitCount + 4'h1;
                     if (bitCount == `SEBFE_ADDR_BITS - 4'h1) begin
                        if (addrMatch) begin
                           state <= ST_ACK_WAIT;
                        end else begin
                           state       <= ST_IDLE;
                           addressNack <= 1'b1;
                        end
                     end
                  end
               end
               ST_ACK_WAIT: begin
                  if (sclFall) begin
                     sdaOe      <= 1'b1;
                     state      <= ST_ACK_DRV;
                     addressAck <= 1'b1;
                     readMode      <= shiftReg[`SEBFE_RW_BIT];
                     selectEeprom  <= shiftReg[7:4] == `SEBFE_TYPE_EEPROM;
                     selectProtect <= shiftReg[7:4] == `SEBFE_TYPE_PROTECT;
                     selectSensor  <= shiftReg[7:4] == `SEBFE_TYPE_SENSOR;
                  end
               end
               ST_ACK_DRV: begin
                  if (sclRise) begin
                     state <= ST_ACK_END;
                  end
               end
               ST_ACK_END: begin
                  // release only after the ninth falling edge
                  if (sclFall) begin
                     sdaOe <= 1'b0;
                     state <= ST_SELECTED;
                  end
               end
               ST_SELECTED: begin
                  // data phase belongs to the selected function
                  sdaOe <= 1'b0;
               end
               default: begin
                  state <= ST_IDLE;
                  sdaOe <= 1'b0;
               end
            endcase
         end
      end
   end

endmodule // sebfe_front_end

// ==== tb/sebfe_chk.sv ====
// checker for the front-end ports
`timescale 1ns/1ps
module sebfe_chk #(
   parameter [23:0] RESET_COMPLETE_CYCLES = 24'd50
) (
   input wire        clk,
   input wire        rst_n,
   input wire        sdaOe,
   input wire        sdaOut,
   input wire        pendingOperation,
   input wire        alertOut,
   input wire        alertOe,
   input wire        resetComplete,
   input wire        standby,
   input wire        sensorMonitoring,
   input wire [7:0]  registerPointer,
   input wire [15:0] upperLimit,
   input wire [15:0] lowerLimit,
   input wire [15:0] criticalLimit,
   input wire [1:0]  hysteresis,
   input wire        alertInterruptMode,
   input wire        alertActiveHigh,
   input wire        alertEnable,
   input wire        eepromPageSelect,
   input wire        startDetect,
   input wire        stopDetect,
   input wire        busTimeout,
   input wire        addressAck,
   input wire        addressNack,
   input wire        selectEeprom,
   input wire        selectProtect,
   input wire        selectSensor
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   reg [31:0] upCount;
   wire       anySel = selectEeprom | selectProtect | selectSensor;
   always @(posedge clk) begin
      if (!rst_n) upCount <= 32'h0;
      else if (!resetComplete) upCount <= upCount + 32'h1;
   end
   a_reset_time: assert property ($rose(resetComplete) |-> upCount >= RESET_COMPLETE_CYCLES - 1
      && upCount <= RESET_COMPLETE_CYCLES + 1) else $error("reset finish time off");
   a_monitor_follow: assert property (sensorMonitoring == $past(resetComplete))
      else $error("monitoring not following reset done");
   a_ptr_default: assert property (registerPointer == 8'h00) else $error("pointer not zero");
   a_limit_defaults: assert property (upperLimit == 16'h0000 && lowerLimit == 16'h0000
      && criticalLimit == 16'h0000 && hysteresis == 2'h0) else $error("limits not zero");
   a_alert_defaults: assert property (!alertOut && !alertOe && !alertInterruptMode && !alertActiveHigh
      && !alertEnable) else $error("alert setup wrong");
   a_sda_open_drain: assert property (!sdaOut) else $error("sda driven high");
   a_page_clear: assert property (eepromPageSelect == 1'b0) else $error("page select set");
   a_stop_standby: assert property (stopDetect && !pendingOperation ##1 !pendingOperation |-> ##[0:2] standby)
      else $error("no standby after stop");
   a_timeout_free: assert property (busTimeout |=> !sdaOe && !anySel) else $error("sda held after timeout");
   a_one_select: assert property ($onehot0({selectEeprom, selectProtect, selectSensor}))
      else $error("two selects at once");
   a_ack_drive: assert property (addressAck |-> sdaOe ##1 sdaOe[*7]) else $error("ack not held");
   a_nack_quiet: assert property (addressNack |=> (!sdaOe && !anySel)[*8]) else $error("nack drove sda");
   a_start_clear: assert property (startDetect |-> ##[0:2] !anySel) else $error("select kept past start");
endmodule // sebfe_chk

bind sebfe_front_end sebfe_chk #(.RESET_COMPLETE_CYCLES(RESET_COMPLETE_CYCLES)) sebfe_chk_i (.*);

// ==== tb/sebfe_master.sv ====
// behavioural two-wire bus master
`timescale 1ns/1ps
module sebfe_master (
   input  wire clk,
   output reg  scl,
   output reg  sdaLow,
   input  wire sda
);
   initial begin
      scl = 1'b1;
      sdaLow = 1'b0;
   end
   task hold(input integer n);
      repeat (n) @(posedge clk);
   endtask
   // low phases far below the timeout
   // start from idle or as repeated start
   task start;
      sdaLow <= 1'b0; hold(4); scl <= 1'b1; hold(4); sdaLow <= 1'b1; hold(4); scl <= 1'b0; hold(4);
   endtask
   task stop;
      sdaLow <= 1'b1; hold(4); scl <= 1'b1; hold(4); sdaLow <= 1'b0; hold(4);
   endtask
   // data changes only while scl is low
   task bitOut(input b, output r);
      sdaLow <= ~b; hold(4); scl <= 1'b1; hold(4); r = sda; hold(4); scl <= 1'b0; hold(4);
   endtask
   // msb first, ninth clock released for the answer
   task sendByte(input [7:0] b, output ack);
      integer k;
      reg     r;
      for (k = 7; k >= 0; k = k - 1) bitOut(b[k], r);
      bitOut(1'b1, r);
      ack = ~r;
   endtask
endmodule // sebfe_master

// ==== tb/tb.sv ====
// self-checking bench for the two-wire front end
`timescale 1ns/1ps
module tb;
   localparam RCC = 50;
   localparam TOC = 40;
   reg        clk, rst_n, pend, ack;
   reg  [2:0] strapPins;
   reg  [3:0] ty;
   wire       scl, mLow, sdaOe, resetComplete, standby, busTimeout, selE, selP, selS, readMode;
   wire       sdaOut, alertOut, alertOe, sensMon, intMode, actHigh, alertEn, pgSel;
   wire       startDet, stopDet, ackPulse, nackPulse;
   wire [7:0] regPtr;
   wire [15:0] upLim, loLim, critLim;
   wire [1:0] hyst;
   reg  [7:0] bt, nStart, nStop, nAck, nNack;
   wire       sda = ~(mLow | (sdaOe & ~sdaOut));
   integer    n_errors, checks_done, i, t;
   sebfe_front_end #(.RESET_COMPLETE_CYCLES(24'd50), .TIMEOUT_CYCLES(16'd40)) sebfe_front_end_i (
      .clk(clk), .rst_n(rst_n), .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
      .strapAddressPins(strapPins), .pendingOperation(pend), .alertOut(alertOut), .alertOe(alertOe),
      .resetComplete(resetComplete), .standby(standby), .sensorMonitoring(sensMon), .registerPointer(regPtr),
      .upperLimit(upLim), .lowerLimit(loLim), .criticalLimit(critLim), .hysteresis(hyst),
      .alertInterruptMode(intMode), .alertActiveHigh(actHigh), .alertEnable(alertEn),
      .eepromPageSelect(pgSel), .startDetect(startDet), .stopDetect(stopDet),
      .busTimeout(busTimeout), .addressAck(ackPulse), .addressNack(nackPulse), .selectEeprom(selE),
      .selectProtect(selP), .selectSensor(selS), .readMode(readMode));
   sebfe_master sebfe_master_i (.clk(clk), .scl(scl), .sdaLow(mLow), .sda(sda));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // pulse counters; expected totals follow from the stimulus below
   always @(posedge clk) begin
      if (!rst_n) begin
         nStart <= 8'h00;
         nStop  <= 8'h00;
         nAck   <= 8'h00;
         nNack  <= 8'h00;
      end else begin
         nStart <= nStart + {7'h00, startDet};
         nStop  <= nStop + {7'h00, stopDet};
         nAck   <= nAck + {7'h00, ackPulse};
         nNack  <= nNack + {7'h00, nackPulse};
      end
   end
   task check(input string nm, input [15:0] e, input [15:0] g);
      checks_done = checks_done + 1;
      if (g !== e) begin
         n_errors = n_errors + 1;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task addr(input [7:0] b, input ea);
      sebfe_master_i.start;
      sebfe_master_i.sendByte(b, ack);
      check("ack", ea, ack);
   endtask
   task idleCheck(input e);
      sebfe_master_i.stop;
      sebfe_master_i.hold(4);
      check("standby", e, standby);
   endtask
   initial begin
      rst_n = 1'b0; pend = 1'b0; strapPins = 3'h5; n_errors = 0; checks_done = 0;
      repeat (5) @(posedge clk);
      #1 check("standby", 1, standby);
      rst_n <= 1'b1;
      for (i = 0; i < RCC + 9 && resetComplete !== 1'b1; i = i + 1) begin
         @(posedge clk);
         #1;
      end
      // done near the shortened reset time
      check("resetTime", 1, resetComplete === 1'b1 && i >= RCC - 2 && i <= RCC + 2);
      $display("test reset done");
      sebfe_master_i.hold(4);
      check("monitoring", 1, sensMon);
      check("pointer", 0, regPtr);
      check("limits", 0, upLim | loLim | critLim);
      check("hysteresis", 0, hyst);
      check("alertSetup", 0, {alertOut, alertOe, intMode, actHigh, alertEn});
      check("pageSelect", 0, pgSel);
      check("sdaOut", 0, sdaOut);
      for (t = 0; t < 6; t = t + 1) begin
         ty = (t < 2) ? 4'hA : (t < 4) ? 4'h6 : 4'h3;
         addr({ty, 3'h5, t[0]}, 1'b1);
         check("selects", {ty == 4'hA, ty == 4'h6, ty == 4'h3}, {selE, selP, selS});
         check("readMode", t[0], readMode);
         idleCheck(1'b1);
      end
      $display("test type ids done");
      addr(8'h5A, 1'b0);
      check("selects", 0, {selE, selP, selS});
      check("standby", 1, standby);
      addr(8'hA8, 1'b0);
      idleCheck(1'b1);
      sebfe_master_i.sendByte(8'hAA, ack);
      check("ack", 0, ack);
      strapPins <= 3'h2;
      sebfe_master_i.hold(4);
      addr(8'h35, 1'b1);
      idleCheck(1'b1);
      $display("test mismatch done");
      // recovery: start, nine clocks, start, stop
      sebfe_master_i.start;
      sebfe_master_i.sendByte(8'hFF, ack);
      sebfe_master_i.start;
      sebfe_master_i.stop;
      addr(8'h34, 1'b1);
      idleCheck(1'b1);
      $display("test recovery done");
      // scl parked low while the device drives its ack
      bt = 8'hA5;
      sebfe_master_i.start;
      for (t = 7; t >= 0; t = t - 1) sebfe_master_i.bitOut(bt[t], ack);
      check("sdaAck", 0, sda);
      for (i = 0; i < TOC + 20 && busTimeout !== 1'b1; i = i + 1) begin
         @(posedge clk);
         #1;
      end
      // timeout after the low count, last bit left scl low four cycles already
      check("timeout", 1, busTimeout === 1'b1 && i >= TOC - 8 && i <= TOC + 4);
      check("sdaFree", 1, sda);
      check("selects", 0, {selE, selP, selS});
      addr(8'hA4, 1'b1);
      check("selE", 1, selE);
      idleCheck(1'b1);
      $display("test timeout done");
      pend <= 1'b1;
      addr(8'h35, 1'b1);
      idleCheck(1'b0);
      pend <= 1'b0;
      sebfe_master_i.hold(4);
      check("standby", 1, standby);
      $display("test pending done");
      check("starts", 15, nStart);
      check("stops", 12, nStop);
      check("acks", 11, nAck);
      check("nacks", 3, nNack);
      conclude;
   end
   initial begin
      #400000;
      n_errors = n_errors + 1;
      conclude;
   end
endmodule // tb
